/* verilog/amp_pkg.sv */
/*
 Shared constants of the class-D protection and modulation block.
 Assumes a single 250 MHz system clock; all timing counts derive from it.
*/
package amp_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int DC_PERSIST_MS = 420;
	localparam int DC_PERSIST_CYC = DC_PERSIST_MS * 1000 * CLK_MHZ;
	localparam int DC_CNT_W = 27;

	// ------------------------------------------------------------------
	// Modulator
	// ------------------------------------------------------------------
	localparam int PWM_W = 8;
	localparam logic [7:0] PWM_MID = 8'h80;
	localparam logic [6:0] OFF_MAX = 7'h7F;
	localparam int AUDIO_W = 12;
	localparam int PROD_W = 19;
	localparam int OUT_SHIFT = 6;
	localparam int PEAK_LIM_SHIFT = 2;

	// ------------------------------------------------------------------
	// Gain selection: linear factors and input-referred DC thresholds
	// ------------------------------------------------------------------
	localparam logic [1:0] GAIN_20DB = 2'h0;
	localparam logic [1:0] GAIN_26DB = 2'h1;
	localparam logic [1:0] GAIN_32DB = 2'h2;
	localparam logic [1:0] GAIN_36DB = 2'h3;
	localparam logic [6:0] GAIN_F_20 = 7'h0A;
	localparam logic [6:0] GAIN_F_26 = 7'h14;
	localparam logic [6:0] GAIN_F_32 = 7'h28;
	localparam logic [6:0] GAIN_F_36 = 7'h3F;
	localparam logic [11:0] DC_THR_20 = 12'h070;
	localparam logic [11:0] DC_THR_26 = 12'h038;
	localparam logic [11:0] DC_THR_32 = 12'h01C;
	localparam logic [11:0] DC_THR_36 = 12'h011;

	// ------------------------------------------------------------------
	// Thermal protection, degrees C
	// ------------------------------------------------------------------
	localparam logic [7:0] TEMP_TRIP_C = 8'h96;
	localparam logic [7:0] TEMP_HYST_C = 8'h0F;

	// ------------------------------------------------------------------
	// Operating states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_RUN = 2'b01,
		ST_THERMAL = 2'b10,
		ST_HIZ = 2'b11
	} amp_state_e;

endpackage : amp_pkg

/* verilog/amp_pwm_mod.sv */
/*
 Bridge pulse-width modulator: free-running period counter and duty compare.
 Assumes duty values are held stable by the caller across a period.
*/
module amp_pwm_mod
	import amp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [PWM_W-1:0] i_pos_duty,
	input wire logic [PWM_W-1:0] i_neg_duty,
	output logic o_pos_raw,
	output logic o_neg_raw,
	output logic o_period_start
);

	logic [PWM_W-1:0] cnt_r;

	// ------------------------------------------------------------------
	// Period counter
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	// Both legs rise together at period start: in phase at zero input
	assign o_pos_raw = (cnt_r < i_pos_duty);
	assign o_neg_raw = (cnt_r < i_neg_duty);
	assign o_period_start = (cnt_r == '0);

endmodule : amp_pwm_mod

/* verilog/amp_fault_protect_modulator.sv */
/*
 Protection and control of a mono filter-free class-D bridge: shutdown,
 DC-offset latch, short-circuit latch, thermal shutdown, PWM and peak limit.
 Assumes all inputs synchronous to I_CLK_SYS; audio is signed mV, temperature
 in degrees C, peak limit a code whose virtual rail is four times its value.
*/
// Behaviour
// - Sleep input low mutes both legs and enters low-current state.
// - Same-polarity imbalance at or beyond threshold longer than 420 ms raises DC fault.
// - DC fault pulls the error output low.
// - DC fault stops amplifying and floats both legs.
// - DC fault latches until bridge supply drops; sleep does not clear it.
// - DC threshold per gain: 112, 56, 28, 17 mV input.
// - Output short pulls the error output low.
// - Short latch floats both legs until cleared.
// - Sleep taken low then high clears the short latch.
// - Die above 150 C enters shutdown with outputs disabled.
// - Thermal fault releases after cooling 15 C, no host action.
// - Thermal shutdown is not reported on the error output.
// - Legs switch rail to rail and in phase at zero input.
// - Positive output: positive leg above half duty, negative leg below.
// - Duty offset capped at four times the peak limit level.
// - Gain select hi,lo: 20, 26, 32, 36 dB.
module amp_fault_protect_modulator
	import amp_pkg::*;
#(
	parameter int DC_PERSIST = DC_PERSIST_CYC
)
(
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_AMP_SLEEP_N,
	input wire logic I_AMP_LEVEL_SEL_HI,
	input wire logic I_AMP_LEVEL_SEL_LO,
	input wire logic signed [AUDIO_W-1:0] I_AUDIO_IN,
	input wire logic [7:0] I_PEAK_LIMIT_LEVEL,
	input wire logic I_SUPPLY_PRESENT,
	input wire logic I_SHORT_DETECT,
	input wire logic [7:0] I_DIE_TEMP,
	output logic O_POS_BRIDGE_OUT,
	output logic O_POS_BRIDGE_OE,
	output logic O_NEG_BRIDGE_OUT,
	output logic O_NEG_BRIDGE_OE,
	output logic O_ERROR_REPORT_N,
	output logic O_ERROR_REPORT_OE,
	output logic O_LOW_POWER
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [6:0] gain_factor(input logic [1:0] sel);
		case (sel)
			GAIN_20DB: gain_factor = GAIN_F_20;
			GAIN_26DB: gain_factor = GAIN_F_26;
			GAIN_32DB: gain_factor = GAIN_F_32;
			default: gain_factor = GAIN_F_36;
		endcase
	endfunction : gain_factor

	function automatic logic [11:0] dc_threshold(input logic [1:0] sel);
		case (sel)
			GAIN_20DB: dc_threshold = DC_THR_20;
			GAIN_26DB: dc_threshold = DC_THR_26;
			GAIN_32DB: dc_threshold = DC_THR_32;
			default: dc_threshold = DC_THR_36;
		endcase
	endfunction : dc_threshold

	function automatic logic [6:0] min7(input logic [PROD_W-1:0] a, input logic [6:0] b);
		min7 = (a > PROD_W'(b)) ? b : a[6:0];
	endfunction : min7

	logic [1:0] gain_sel;
	logic in_neg;
	logic [AUDIO_W-1:0] in_mag;
	logic [PROD_W-1:0] amp_mag;
	logic [PROD_W-1:0] rail_lim;
	logic [6:0] off;
	logic [PWM_W-1:0] pos_duty_nxt;
	logic [PWM_W-1:0] neg_duty_nxt;
	logic [PWM_W-1:0] pos_duty_r;
	logic [PWM_W-1:0] neg_duty_r;
	logic pos_raw;
	logic neg_raw;
	logic period_start;
	logic over_thr;
	logic pol_r;
	logic [DC_CNT_W-1:0] dc_cnt_r;
	logic dc_fault_r;
	logic short_r;
	logic thermal_r;
	logic fault_any;
	amp_state_e state_r;
	amp_state_e state_nxt;

	// ------------------------------------------------------------------
	// Gain, limit and duty
	// ------------------------------------------------------------------
	assign gain_sel = {I_AMP_LEVEL_SEL_HI, I_AMP_LEVEL_SEL_LO};
	assign in_neg = I_AUDIO_IN[AUDIO_W-1];
	assign in_mag = in_neg ? AUDIO_W'(-I_AUDIO_IN) : AUDIO_W'(I_AUDIO_IN);
	assign amp_mag = (PROD_W'(in_mag) * PROD_W'(gain_factor(gain_sel))) >> OUT_SHIFT;
	assign rail_lim = PROD_W'(I_PEAK_LIMIT_LEVEL) << PEAK_LIM_SHIFT;
	assign off = min7(amp_mag, min7(rail_lim, OFF_MAX));

	always_comb
	begin
		if (in_neg)
		begin
			pos_duty_nxt = PWM_MID - PWM_W'(off);
			neg_duty_nxt = PWM_MID + PWM_W'(off);
		end
		else
		begin
			pos_duty_nxt = PWM_MID + PWM_W'(off);
			neg_duty_nxt = PWM_MID - PWM_W'(off);
		end
	end

	// Duty only changes at a period boundary to avoid runt pulses
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
		begin
			pos_duty_r <= PWM_MID;
			neg_duty_r <= PWM_MID;
		end
		else if (period_start)
		begin
			pos_duty_r <= pos_duty_nxt;
			neg_duty_r <= neg_duty_nxt;
		end
	end

	amp_pwm_mod u_pwm (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_pos_duty(pos_duty_r),
		.i_neg_duty(neg_duty_r),
		.o_pos_raw(pos_raw),
		.o_neg_raw(neg_raw),
		.o_period_start(period_start)
	);

	// ------------------------------------------------------------------
	// DC-offset detection
	// ------------------------------------------------------------------
	assign over_thr = (in_mag >= dc_threshold(gain_sel));

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
		begin
			dc_cnt_r <= '0;
			pol_r <= 1'b0;
		end
		else if (state_r != ST_RUN || !over_thr || in_neg != pol_r)
		begin
			dc_cnt_r <= '0;
			pol_r <= in_neg;
		end
		else if (dc_cnt_r != DC_CNT_W'(DC_PERSIST))
			dc_cnt_r <= dc_cnt_r + 1'b1;
	end

	// Only a supply drop clears it
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
			dc_fault_r <= 1'b0;
		else if (state_r == ST_RUN && over_thr && in_neg == pol_r &&
			dc_cnt_r == DC_CNT_W'(DC_PERSIST))
			dc_fault_r <= 1'b1;
		else if (!I_SUPPLY_PRESENT)
			dc_fault_r <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Short-circuit latch and thermal hysteresis
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
			short_r <= 1'b0;
		else if (I_SHORT_DETECT && state_r == ST_RUN)
			short_r <= 1'b1;
		else if (!I_AMP_SLEEP_N)
			short_r <= 1'b0;
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
			thermal_r <= 1'b0;
		else if (I_DIE_TEMP > TEMP_TRIP_C)
			thermal_r <= 1'b1;
		else if (I_DIE_TEMP <= TEMP_TRIP_C - TEMP_HYST_C)
			thermal_r <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Operating state
	// ------------------------------------------------------------------
	assign fault_any = dc_fault_r | short_r;

	always_comb
	begin
		if (fault_any || !I_SUPPLY_PRESENT)
			state_nxt = ST_HIZ;
		else if (thermal_r)
			state_nxt = ST_THERMAL;
		else if (!I_AMP_SLEEP_N)
			state_nxt = ST_SLEEP;
		else
			state_nxt = ST_RUN;
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
			state_r <= ST_SLEEP;
		else
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------------
	// Registered pins
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
		begin
			O_POS_BRIDGE_OUT <= 1'b0;
			O_NEG_BRIDGE_OUT <= 1'b0;
			O_POS_BRIDGE_OE <= 1'b0;
			O_NEG_BRIDGE_OE <= 1'b0;
			O_LOW_POWER <= 1'b1;
		end
		else
		begin
			case (state_r)
				ST_RUN:
				begin
					O_POS_BRIDGE_OUT <= pos_raw;
					O_NEG_BRIDGE_OUT <= neg_raw;
					O_POS_BRIDGE_OE <= 1'b1;
					O_NEG_BRIDGE_OE <= 1'b1;
					O_LOW_POWER <= 1'b0;
				end
				ST_SLEEP:
				begin
					O_POS_BRIDGE_OUT <= 1'b0;
					O_NEG_BRIDGE_OUT <= 1'b0;
					O_POS_BRIDGE_OE <= 1'b1;
					O_NEG_BRIDGE_OE <= 1'b1;
					O_LOW_POWER <= 1'b1;
				end
				default:
				begin
					O_POS_BRIDGE_OUT <= 1'b0;
					O_NEG_BRIDGE_OUT <= 1'b0;
					O_POS_BRIDGE_OE <= 1'b0;
					O_NEG_BRIDGE_OE <= 1'b0;
					O_LOW_POWER <= 1'b1;
				end
			endcase
		end
	end

	// Open-drain fault pin, thermal excluded
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN)
		begin
			O_ERROR_REPORT_N <= 1'b1;
			O_ERROR_REPORT_OE <= 1'b0;
		end
		else
		begin
			O_ERROR_REPORT_N <= ~fault_any;
			O_ERROR_REPORT_OE <= fault_any;
		end
	end

endmodule : amp_fault_protect_modulator

/* verification/amp_fault_checker.sv */
/*
 Port checker of the amplifier protection block, bound to its top module.
 Assumes one clock and a synchronous active-low reset.
*/
module amp_fault_checker
	import amp_pkg::*;
#(
	parameter int DC_PERSIST = 50
)
(
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic I_AMP_SLEEP_N,
	input wire logic signed [AUDIO_W-1:0] I_AUDIO_IN,
	input wire logic I_SUPPLY_PRESENT,
	input wire logic I_SHORT_DETECT,
	input wire logic [7:0] I_DIE_TEMP,
	input wire logic O_POS_BRIDGE_OUT,
	input wire logic O_POS_BRIDGE_OE,
	input wire logic O_NEG_BRIDGE_OUT,
	input wire logic O_NEG_BRIDGE_OE,
	input wire logic O_ERROR_REPORT_N,
	input wire logic O_ERROR_REPORT_OE,
	input wire logic O_LOW_POWER
);
	// ------------------------------------------------------------
	// Cycles the audio input has held one value
	// ------------------------------------------------------------
	logic [9:0] held_r;
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RSTN);
	always_ff @(posedge I_CLK_SYS)
	begin
		if (!I_RSTN || !$stable(I_AUDIO_IN))
			held_r <= 10'h000;
		else if (held_r != 10'h200)
			held_r <= held_r + 10'h001;
	end
	property p_od;
		O_ERROR_REPORT_N != O_ERROR_REPORT_OE;
	endproperty
	a_od: assert property (p_od) else $error("fault pin and enable disagree");
	property p_float;
		$fell(O_ERROR_REPORT_N) |=> !O_POS_BRIDGE_OE && !O_NEG_BRIDGE_OE;
	endproperty
	a_float: assert property (p_float) else $error("legs driven after fault");
	property p_mute;
		!I_AMP_SLEEP_N [*3] |-> O_LOW_POWER && !(O_POS_BRIDGE_OE && O_POS_BRIDGE_OUT)
			&& !(O_NEG_BRIDGE_OE && O_NEG_BRIDGE_OUT);
	endproperty
	a_mute: assert property (p_mute) else $error("sleep did not mute");
	property p_hot;
		(I_DIE_TEMP > TEMP_TRIP_C) [*4] |-> !O_POS_BRIDGE_OE && !O_NEG_BRIDGE_OE && O_LOW_POWER;
	endproperty
	a_hot: assert property (p_hot) else $error("legs driven while hot");
	property p_resume;
		(I_DIE_TEMP <= TEMP_TRIP_C - TEMP_HYST_C && I_AMP_SLEEP_N && I_SUPPLY_PRESENT
			&& !I_SHORT_DETECT && O_ERROR_REPORT_N) [*4] |-> O_POS_BRIDGE_OE && !O_LOW_POWER;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume when cool");
	property p_hold;
		$past(I_AMP_SLEEP_N && I_SUPPLY_PRESENT) && !O_ERROR_REPORT_N |=> !O_ERROR_REPORT_N;
	endproperty
	a_hold: assert property (p_hold) else $error("fault released early");
	property p_clear;
		(!I_SUPPLY_PRESENT && !I_AMP_SLEEP_N) [*2] |=> O_ERROR_REPORT_N;
	endproperty
	a_clear: assert property (p_clear) else $error("fault not cleared");
	property p_phase;
		held_r == 10'h200 && I_AUDIO_IN == 0 |-> O_POS_BRIDGE_OUT == O_NEG_BRIDGE_OUT;
	endproperty
	a_phase: assert property (p_phase) else $error("legs out of phase");
	property p_lead;
		held_r == 10'h200 && I_AUDIO_IN > 0 |-> !(O_NEG_BRIDGE_OUT && !O_POS_BRIDGE_OUT);
	endproperty
	a_lead: assert property (p_lead) else $error("negative leg leads");
endmodule : amp_fault_checker

bind amp_fault_protect_modulator amp_fault_checker #(.DC_PERSIST(DC_PERSIST)) u_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_AMP_SLEEP_N(I_AMP_SLEEP_N),
	.I_AUDIO_IN(I_AUDIO_IN), .I_SUPPLY_PRESENT(I_SUPPLY_PRESENT),
	.I_SHORT_DETECT(I_SHORT_DETECT), .I_DIE_TEMP(I_DIE_TEMP),
	.O_POS_BRIDGE_OUT(O_POS_BRIDGE_OUT), .O_POS_BRIDGE_OE(O_POS_BRIDGE_OE),
	.O_NEG_BRIDGE_OUT(O_NEG_BRIDGE_OUT), .O_NEG_BRIDGE_OE(O_NEG_BRIDGE_OE),
	.O_ERROR_REPORT_N(O_ERROR_REPORT_N), .O_ERROR_REPORT_OE(O_ERROR_REPORT_OE),
	.O_LOW_POWER(O_LOW_POWER));

/* verification/amp_host_model.sv */
/*
 Host model: drives the sleep input and the bridge supply.
 Assumes the fault line is resolved with a pull-up by the bench.
*/
module amp_host_model
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_play,
	input wire logic i_power,
	input wire logic i_auto,
	input wire logic i_fault_n,
	output logic o_sleep_n,
	output logic o_supply
);
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			o_sleep_n <= 1'b0;
		else
			o_sleep_n <= i_play && i_power && (i_fault_n || !i_auto);
	end
	// Supply drops only once sleep is already low
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn || i_power)
			o_supply <= 1'b1;
		else if (!o_sleep_n)
			o_supply <= 1'b0;
	end
endmodule : amp_host_model

/* verification/tb_amp_fault_protect_modulator.sv */
/*
 Self-checking bench of the amplifier protection block.
 Assumes the checker binds itself; the host model drives sleep and supply.
*/
module tb_amp_fault_protect_modulator
	import amp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rstn = 0, play = 0, power = 1, auto_rec = 0, hi = 0, lo = 0, shrt = 0;
	logic signed [11:0] audio = 12'h000;
	logic [7:0] plim = 8'h00, temp = 8'h19;
	logic [15:0] seed = 16'hCBB8;
	wire sleep_n, supply, pos, pos_oe, neg, neg_oe, err_n, err_oe, lowp;
	wire fault_n = err_oe ? err_n : 1'b1;
	int failures = 0, n_tests = 0, np, nn, a, pl, e;
	always #2 clk = ~clk;
	amp_fault_protect_modulator #(.DC_PERSIST(50)) dut (.I_CLK_SYS(clk), .I_RSTN(rstn),
		.I_AMP_SLEEP_N(sleep_n), .I_AMP_LEVEL_SEL_HI(hi), .I_AMP_LEVEL_SEL_LO(lo),
		.I_AUDIO_IN(audio), .I_PEAK_LIMIT_LEVEL(plim), .I_SUPPLY_PRESENT(supply),
		.I_SHORT_DETECT(shrt), .I_DIE_TEMP(temp), .O_POS_BRIDGE_OUT(pos),
		.O_POS_BRIDGE_OE(pos_oe), .O_NEG_BRIDGE_OUT(neg), .O_NEG_BRIDGE_OE(neg_oe),
		.O_ERROR_REPORT_N(err_n), .O_ERROR_REPORT_OE(err_oe), .O_LOW_POWER(lowp));
	amp_host_model host (.i_clk(clk), .i_rstn(rstn), .i_play(play), .i_power(power),
		.i_auto(auto_rec), .i_fault_n(fault_n), .o_sleep_n(sleep_n), .o_supply(supply));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : next_rand
	function automatic int gf(input int g);
		return (g == 0) ? 10 : (g == 1) ? 20 : (g == 2) ? 40 : 63;
	endfunction : gf
	function automatic int thr(input int g);
		return (g == 0) ? 112 : (g == 1) ? 56 : (g == 2) ? 28 : 17;
	endfunction : thr
	function automatic int exp_off(input int v, input int g, input int p);
		int m;
		m = ((v < 0) ? -v : v) * gf(g) >> 6;
		if (m > 4 * p)
			m = 4 * p;
		return (m > 127) ? 127 : m;
	endfunction : exp_off
	task automatic summarize();
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic meas();
		np = 0;
		nn = 0;
		repeat (256)
		begin
			@(negedge clk);
			np += pos;
			nn += neg;
		end
	endtask : meas
	task automatic wait_fault(input int lim);
		int i;
		for (i = 0; i < lim && fault_n !== 1'b0; i++)
			@(negedge clk);
		if (fault_n !== 1'b0)
		begin
			failures++;
			summarize();
		end
	endtask : wait_fault
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		cyc(2);
		rstn <= 1'b1;
		cyc(6);
		@(negedge clk);
		chk({pos_oe, pos, neg_oe, neg, lowp, fault_n}, 16'h002B);
		for (int k = 0; k < 9; k++)
		begin
			cyc(1);
			seed = next_rand(seed);
			a = (k == 8) ? 0 : (k == 0) ? thr(0) - 1 : int'(seed[10:0]) % thr(k % 4);
			a = seed[15] ? -a : a;
			pl = seed[14:12];
			play <= 1'b1;
			{hi, lo} <= 2'(k);
			audio <= 12'(a);
			plim <= 8'(pl);
			cyc(520);
			meas();
			e = exp_off(a, k % 4, pl);
			chk(np, (a >= 0) ? 128 + e : 128 - e);
			chk(nn, (a >= 0) ? 128 - e : 128 + e);
		end
		for (int k = 0; k < 4; k++)
		begin
			cyc(1);
			{hi, lo} <= 2'(k);
			audio <= 12'(thr(k) - 1);
			cyc(100);
			repeat (3)
			begin
				audio <= 12'(thr(k));
				cyc(30);
				audio <= 12'(-thr(k));
				cyc(30);
			end
			@(negedge clk);
			chk(fault_n, 1);
			wait_fault(80);
			cyc(3);
			play <= 1'b0;
			cyc(5);
			play <= 1'b1;
			cyc(8);
			@(negedge clk);
			chk({fault_n, pos_oe, neg_oe, lowp}, 16'h0001);
			cyc(1);
			audio <= 12'h000;
			power <= 1'b0;
			cyc(6);
			power <= 1'b1;
			cyc(10);
			@(negedge clk);
			chk({fault_n, pos_oe, lowp}, 16'h0006);
		end
		for (int k = 0; k < 2; k++)
		begin
			cyc(1);
			auto_rec <= k[0];
			shrt <= 1'b1;
			cyc(1);
			shrt <= 1'b0;
			wait_fault(10);
			cyc(2);
			@(negedge clk);
			chk({fault_n, pos_oe, neg_oe}, 16'h0000);
			cyc(k == 0 ? 20 : 30);
			play <= k[0];
			cyc(5);
			play <= 1'b1;
			cyc(8);
			@(negedge clk);
			chk({fault_n, pos_oe, neg_oe}, 16'h0007);
		end
		for (int i = 0; i < 4; i++)
		begin
			cyc(1);
			temp <= (i == 0) ? 8'h96 : (i == 1) ? 8'h97 : (i == 2) ? 8'h88 : 8'h87;
			cyc(6);
			@(negedge clk);
			chk({pos_oe, neg_oe, lowp, fault_n}, (i == 0 || i == 3) ? 16'h000D : 16'h0003);
		end
		summarize();
	end
endmodule : tb_amp_fault_protect_modulator
